// ===== src/dcsp_pkg.sv
// constants shared by the display cache sdram port and its fifo
// assumes a 100 mhz ref_clk; all timing counts except cas latency and init refreshes are derived from nanoseconds
package dcsp_pkg;

	// ====================================================
	// clock and timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int T_RCD_NS        = 20;
	localparam int T_RP_NS         = 20;
	localparam int T_RFC_NS        = 70;
	localparam int T_MRD_NS        = 20;
	localparam int T_REFI_NS       = 15625;
	localparam int T_INIT_NS       = 100000;
	// least times round up, the refresh interval rounds down
	localparam int RCD_CYC  = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RP_CYC   = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RFC_CYC  = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MRD_CYC  = (T_MRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REFI_CYC = T_REFI_NS / CLK_PERIOD_NS;
	localparam int INIT_CYC = (T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAS_LATENCY = 2;
	localparam int INIT_REFRESHES = 2;

	// ====================================================
	// bus widths and address split
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int MASK_W = 4;
	localparam int COL_W  = 8;
	localparam int REQ_ADDR_W = ADDR_W + COL_W;
	localparam int FIFO_DEPTH = 16;

	// ====================================================
	// commands as {chip select, row, column, write enable}, all active low
	localparam logic [3:0] CMD_DESELECT  = 4'hF;
	localparam logic [3:0] CMD_NOP       = 4'h7;
	localparam logic [3:0] CMD_ACTIVE    = 4'h3;
	localparam logic [3:0] CMD_READ      = 4'h5;
	localparam logic [3:0] CMD_WRITE     = 4'h4;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_REFRESH   = 4'h1;
	localparam logic [3:0] CMD_MODE_SET  = 4'h0;

	// burst of one, sequential, cas latency two
	localparam logic [11:0] MODE_WORD    = 12'h020;
	localparam logic [11:0] PRE_ALL_ADDR = 12'h400;

	localparam logic FSEL_RESET = 1'b1;

endpackage

// ===== src/dcsp_stream_if.sv
// valid/ready word carrier between the port controller and its fifo
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none
interface dcsp_stream_if #(parameter int WIDTH = 32);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== src/dcsp_fifo.sv
// read data fifo: storage array plus a registered output word
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module dcsp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic   ref_clk,
	input  wire logic   rst,
	dcsp_stream_if.sink   fill,
	dcsp_stream_if.source drain
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wptr;
	logic [PW-1:0]    rptr;
	logic [CW-1:0]    count;
	logic             out_valid;
	logic [WIDTH-1:0] out_data;
	logic [PW-1:0]    next_wptr;
	logic [PW-1:0]    next_rptr;
	logic [CW-1:0]    next_count;
	logic             next_out_valid;
	logic [WIDTH-1:0] next_out_data;
	logic             push;
	logic             pop;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	// ====================================================
	// pointers and output stage
	assign fill.ready  = (count != CW'(DEPTH));
	assign drain.valid = out_valid;
	assign drain.data  = out_data;

	always_comb
	begin
		push = fill.valid && fill.ready;
		pop  = (count != '0) && (!out_valid || drain.ready);
		next_wptr = push ? bump(wptr) : wptr;
		next_rptr = pop ? bump(rptr) : rptr;
		next_count = count;
		if (push && !pop)
		begin
			next_count = count + CW'(1);
		end
		else if (pop && !push)
		begin
			next_count = count - CW'(1);
		end
		next_out_data  = pop ? mem[rptr] : out_data;
		next_out_valid = pop || (out_valid && !drain.ready);
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			wptr      <= '0;
			rptr      <= '0;
			count     <= '0;
			out_valid <= 1'b0;
			out_data  <= '0;
		end
		else
		begin
			wptr      <= next_wptr;
			rptr      <= next_rptr;
			count     <= next_count;
			out_valid <= next_out_valid;
			out_data  <= next_out_data;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (push)
		begin
			mem[wptr] <= fill.data;
		end
	end

endmodule
`default_nettype wire

// ===== src/dcsp_port.sv
// display cache sdram port: init, refresh, single word reads and writes
// assumes strap and cpu reset pins are asynchronous, user side is ref_clk
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - drive cache pins only with graphics enabled
// - chip select low selects components when active
// - masks are read output enables, write byte enables
// - row strobe encodes commands, latches row address
// - row and column share twelve bit address
// - write enable low on every write
// - thirty two bit bidirectional data bus
// - sample frequency strap at cpu reset release
// - strap high 133 mhz, low 100 mhz
// - weak pull-up on strap during reset
module dcsp_port #(
	parameter int INIT_CYCLES = dcsp_pkg::INIT_CYC,
	parameter int FIFO_DEPTH  = dcsp_pkg::FIFO_DEPTH
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        graphics_enabled,
	input  wire logic        processor_reset_n,
	input  wire logic        cache_frequency_select,
	output logic             cache_fsel_pullup_en,
	output logic             cache_freq_133,
	output logic             cache_pins_owned,
	output logic             cache_chip_select_n,
	output logic             cache_row_strobe_n,
	output logic             cache_column_strobe_n,
	output logic             cache_write_enable_n,
	output logic [11:0]      cache_mem_address,
	output logic [3:0]       cache_data_mask,
	input  wire logic [31:0] cache_mem_data_in,
	output logic [31:0]      cache_mem_data_out,
	output logic             cache_mem_data_oe,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic        req_write,
	input  wire logic [19:0] req_addr,
	input  wire logic [31:0] req_wdata,
	input  wire logic [3:0]  req_byte_en,
	output logic             rd_valid,
	input  wire logic        rd_ready,
	output logic [31:0]      rd_data
);
	typedef enum logic [3:0] {
		ST_INIT_WAIT, ST_PRE_ALL, ST_REFRESH, ST_MODE, ST_IDLE,
		ST_ACTIVE, ST_ACCESS, ST_LATENCY, ST_PRECHARGE, ST_WAIT
	} dcsp_state_e;

	localparam int CNT_W = 17;

	// ====================================================
	// strap and cpu reset pins, three stage filtered
	logic [2:0] fsel_sync;
	logic [2:0] preset_sync;
	logic       preset_filt;
	logic       next_preset_filt;
	logic       freq_133;
	logic       next_freq_133;

	always_comb
	begin
		next_preset_filt = preset_filt;
		if (preset_sync[1] == preset_sync[2])
		begin
			next_preset_filt = preset_sync[2];
		end
		next_freq_133 = freq_133;
		// release edge of cpu reset fixes the cache frequency
		if (!preset_filt && next_preset_filt && fsel_sync[1] == fsel_sync[2])
		begin
			next_freq_133 = fsel_sync[2];
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			fsel_sync   <= {3{dcsp_pkg::FSEL_RESET}};
			preset_sync <= 3'h0;
			preset_filt <= 1'b0;
			freq_133    <= dcsp_pkg::FSEL_RESET;
		end
		else
		begin
			fsel_sync   <= {fsel_sync[1:0], cache_frequency_select};
			preset_sync <= {preset_sync[1:0], processor_reset_n};
			preset_filt <= next_preset_filt;
			freq_133    <= next_freq_133;
		end
	end

	// pull-up stays on until the filtered release is seen
	assign cache_fsel_pullup_en = !preset_filt;
	assign cache_freq_133       = freq_133;

	// ====================================================
	// command sequencer
	dcsp_state_e      state;
	dcsp_state_e      after;
	logic [CNT_W-1:0] wait_cnt;
	logic [15:0]      refi_cnt;
	logic [1:0]       init_refs;
	logic             refresh_due;
	logic             owned;
	logic [3:0]       cmd;
	logic [11:0]      addr;
	logic [3:0]       mask;
	logic [31:0]      wdata;
	logic             wdata_oe;
	logic             cur_write;
	logic [19:0]      cur_addr;
	dcsp_state_e      next_state;
	dcsp_state_e      next_after;
	logic [CNT_W-1:0] next_wait_cnt;
	logic [15:0]      next_refi_cnt;
	logic [1:0]       next_init_refs;
	logic             next_refresh_due;
	logic             next_owned;
	logic [3:0]       next_cmd;
	logic [11:0]      next_addr;
	logic [3:0]       next_mask;
	logic [31:0]      next_wdata;
	logic             next_wdata_oe;
	logic             next_cur_write;
	logic [19:0]      next_cur_addr;
	logic             take;

	dcsp_stream_if #(.WIDTH(dcsp_pkg::DATA_W)) rd_fill ();
	dcsp_stream_if #(.WIDTH(dcsp_pkg::DATA_W)) rd_drain ();

	function automatic logic [CNT_W-1:0] cyc(input int n);
		// the wait state itself costs one cycle, so load one less
		cyc = (n > 1) ? CNT_W'(n - 1) : CNT_W'(1);
	endfunction

	// reads wait for fifo room so a stalled drain holds off further reads only; writes and refreshes go on
	assign take = req_valid && !refresh_due && graphics_enabled &&
		(req_write || rd_fill.ready);
	assign req_ready = (state == ST_IDLE) && take;

	always_comb
	begin
		next_state       = state;
		next_after       = after;
		next_wait_cnt    = wait_cnt;
		next_init_refs   = init_refs;
		next_cur_write   = cur_write;
		next_cur_addr    = cur_addr;
		// idle bus sees deselect, strobes high
		next_cmd         = dcsp_pkg::CMD_DESELECT;
		next_addr        = addr;
		next_mask        = 4'hF;
		next_wdata       = wdata;
		next_wdata_oe    = 1'b0;
		next_owned       = owned;
		next_refi_cnt    = (refi_cnt == '0) ? '0 : refi_cnt - 16'(1);
		next_refresh_due = refresh_due || (refi_cnt == '0);
		rd_fill.valid    = 1'b0;
		rd_fill.data     = cache_mem_data_in;
		case (state)
			ST_INIT_WAIT:
			begin
				// pins only taken over with graphics enabled
				next_owned = graphics_enabled;
				if (!graphics_enabled)
				begin
					next_wait_cnt = CNT_W'(INIT_CYCLES);
				end
				else if (wait_cnt == '0)
				begin
					next_state = ST_PRE_ALL;
				end
				else
				begin
					next_wait_cnt = wait_cnt - CNT_W'(1);
				end
			end
			ST_PRE_ALL:
			begin
				next_cmd       = dcsp_pkg::CMD_PRECHARGE;
				next_addr      = dcsp_pkg::PRE_ALL_ADDR;
				next_init_refs = 2'(dcsp_pkg::INIT_REFRESHES);
				next_wait_cnt  = cyc(dcsp_pkg::RP_CYC);
				next_after     = ST_REFRESH;
				next_state     = ST_WAIT;
			end
			ST_REFRESH:
			begin
				next_cmd         = dcsp_pkg::CMD_REFRESH;
				next_refresh_due = 1'b0;
				next_refi_cnt    = 16'(dcsp_pkg::REFI_CYC);
				next_wait_cnt    = cyc(dcsp_pkg::RFC_CYC);
				next_state       = ST_WAIT;
				if (init_refs == 2'h0)
				begin
					next_after = ST_IDLE;
				end
				else
				begin
					next_init_refs = init_refs - 2'h1;
					next_after = (init_refs == 2'h1) ? ST_MODE : ST_REFRESH;
				end
			end
			ST_MODE:
			begin
				next_cmd      = dcsp_pkg::CMD_MODE_SET;
				next_addr     = dcsp_pkg::MODE_WORD;
				next_wait_cnt = cyc(dcsp_pkg::MRD_CYC);
				next_after    = ST_IDLE;
				next_state    = ST_WAIT;
			end
			ST_IDLE:
			begin
				if (!graphics_enabled)
				begin
					next_owned    = 1'b0;
					next_wait_cnt = CNT_W'(INIT_CYCLES);
					next_state    = ST_INIT_WAIT;
				end
				else if (refresh_due)
				begin
					next_state = ST_REFRESH;
				end
				else if (take)
				begin
					next_cur_write = req_write;
					next_cur_addr  = req_addr;
					next_wdata     = req_wdata;
					// inverse of byte enables masks unwritten lanes
					next_mask      = req_write ? ~req_byte_en : 4'hF;
					next_state     = ST_ACTIVE;
				end
			end
			ST_ACTIVE:
			begin
				// row strobe low latches the row half of the address
				next_cmd      = dcsp_pkg::CMD_ACTIVE;
				next_addr     = cur_addr[19:8];
				next_mask     = mask;
				next_wait_cnt = cyc(dcsp_pkg::RCD_CYC);
				next_after    = ST_ACCESS;
				next_state    = ST_WAIT;
			end
			ST_ACCESS:
			begin
				// column strobe low latches the column half
				// write enable low marks a write
				next_cmd  = cur_write ? dcsp_pkg::CMD_WRITE : dcsp_pkg::CMD_READ;
				next_addr = {4'h0, cur_addr[7:0]};
				// reads unmask all lanes as output enables
				next_mask = cur_write ? mask : 4'h0;
				// drive write data on the shared bus
				next_wdata_oe = cur_write;
				// the memory sees the command one edge after launch
				next_wait_cnt = CNT_W'(dcsp_pkg::CAS_LATENCY + 1);
				next_state    = cur_write ? ST_PRECHARGE : ST_LATENCY;
			end
			ST_LATENCY:
			begin
				next_cmd = dcsp_pkg::CMD_NOP;
				if (wait_cnt == CNT_W'(1))
				begin
					// room was reserved before the read was issued
					rd_fill.valid = 1'b1;
					next_state    = ST_PRECHARGE;
				end
				else
				begin
					next_wait_cnt = wait_cnt - CNT_W'(1);
				end
			end
			ST_PRECHARGE:
			begin
				next_cmd      = dcsp_pkg::CMD_PRECHARGE;
				next_addr     = dcsp_pkg::PRE_ALL_ADDR;
				next_wait_cnt = cyc(dcsp_pkg::RP_CYC);
				next_after    = ST_IDLE;
				next_state    = ST_WAIT;
			end
			ST_WAIT:
			begin
				next_cmd = dcsp_pkg::CMD_NOP;
				// write lane mask must survive the row to column wait
				next_mask = mask;
				if (wait_cnt <= CNT_W'(1))
				begin
					next_state = after;
				end
				else
				begin
					next_wait_cnt = wait_cnt - CNT_W'(1);
				end
			end
			default:
			begin
				next_state = ST_INIT_WAIT;
			end
		endcase
		if (!graphics_enabled)
		begin
			next_owned = 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state       <= ST_INIT_WAIT;
			after       <= ST_IDLE;
			wait_cnt    <= CNT_W'(INIT_CYCLES);
			refi_cnt    <= 16'(dcsp_pkg::REFI_CYC);
			init_refs   <= 2'h0;
			refresh_due <= 1'b0;
			owned       <= 1'b0;
			cmd         <= dcsp_pkg::CMD_DESELECT;
			addr        <= 12'h000;
			mask        <= 4'hF;
			wdata       <= 32'h0000_0000;
			wdata_oe    <= 1'b0;
			cur_write   <= 1'b0;
			cur_addr    <= 20'h00000;
		end
		else
		begin
			state       <= next_state;
			after       <= next_after;
			wait_cnt    <= next_wait_cnt;
			refi_cnt    <= next_refi_cnt;
			init_refs   <= next_init_refs;
			refresh_due <= next_refresh_due;
			owned       <= next_owned;
			cmd         <= next_cmd;
			addr        <= next_addr;
			mask        <= next_mask;
			wdata       <= next_wdata;
			wdata_oe    <= next_wdata_oe;
			cur_write   <= next_cur_write;
			cur_addr    <= next_cur_addr;
		end
	end

	// ====================================================
	// pins; unowned pins stay quiet for the graphics port
	assign cache_pins_owned      = owned;
	assign cache_chip_select_n   = owned ? cmd[3] : 1'b1;
	assign cache_row_strobe_n    = owned ? cmd[2] : 1'b1;
	assign cache_column_strobe_n = owned ? cmd[1] : 1'b1;
	assign cache_write_enable_n  = owned ? cmd[0] : 1'b1;
	assign cache_mem_address     = addr;
	assign cache_data_mask       = mask;
	assign cache_mem_data_out    = wdata;
	assign cache_mem_data_oe     = owned && wdata_oe;

	dcsp_fifo #(
		.WIDTH (dcsp_pkg::DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_rd_fifo (
		.ref_clk (ref_clk),
		.rst     (rst),
		.fill    (rd_fill),
		.drain   (rd_drain)
	);

	assign rd_valid       = rd_drain.valid;
	assign rd_data        = rd_drain.data;
	assign rd_drain.ready = rd_ready;

endmodule
`default_nettype wire

// ===== tb/dcsp_port_asserts.sv
// pin level checker for the display cache sdram port
// assumes it is bound onto dcsp_port; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module dcsp_port_asserts (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        graphics_enabled,
	input wire logic        processor_reset_n,
	input wire logic        cache_fsel_pullup_en,
	input wire logic        cache_freq_133,
	input wire logic        cache_pins_owned,
	input wire logic        cache_chip_select_n,
	input wire logic        cache_row_strobe_n,
	input wire logic        cache_column_strobe_n,
	input wire logic        cache_write_enable_n,
	input wire logic [11:0] cache_mem_address,
	input wire logic [3:0]  cache_data_mask,
	input wire logic [31:0] cache_mem_data_out,
	input wire logic        cache_mem_data_oe,
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic        req_write,
	input wire logic [19:0] req_addr,
	input wire logic [31:0] req_wdata,
	input wire logic [3:0]  req_byte_en
);
	// ====================================================
	// helpers
	wire logic [3:0]  cmd = {cache_chip_select_n, cache_row_strobe_n,
		cache_column_strobe_n, cache_write_enable_n};
	wire logic        take = req_valid && req_ready;
	wire logic [11:0] req_row = req_addr[19:8];
	wire logic [7:0]  req_col = req_addr[7:0];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ====================================================
	// assertions
	idle_deselect_a: assert property (!cache_pins_owned |-> cmd == 4'hF)
		else $error("strobes active without pin ownership");
	own_drop_a: assert property (!graphics_enabled |=> !cache_pins_owned)
		else $error("pins kept with graphics disabled");
	cs_select_a: assert property (
		cache_pins_owned && !cache_column_strobe_n |-> !cache_chip_select_n)
		else $error("column strobe without chip select");
	rd_mask_a: assert property (
		cmd == dcsp_pkg::CMD_READ |-> cache_data_mask == 4'h0)
		else $error("read issued with data masked");
	row_col_a: assert property (
		take |-> ##2 (cmd == dcsp_pkg::CMD_ACTIVE &&
		cache_mem_address == $past(req_row, 2)) ##2
		(!cache_column_strobe_n &&
		cache_mem_address == {4'h0, $past(req_col, 4)}))
		else $error("row or column address wrong");
	wr_data_a: assert property (
		take && req_write |-> ##4 (cmd == dcsp_pkg::CMD_WRITE &&
		cache_mem_data_oe &&
		cache_data_mask == ~$past(req_byte_en, 4) &&
		cache_mem_data_out == $past(req_wdata, 4)))
		else $error("write cycle fields wrong");
	oe_write_a: assert property (cache_mem_data_oe |-> cmd == dcsp_pkg::CMD_WRITE)
		else $error("data driven outside a write");
	rst_strap_a: assert property ($fell(rst) |-> cache_freq_133 && cache_fsel_pullup_en)
		else $error("strap outputs wrong after reset");
	pullup_a: assert property (!processor_reset_n [*5] |-> cache_fsel_pullup_en)
		else $error("pull-up off during processor reset");
	strap_hold_a: assert property (!processor_reset_n [*5] |=> $stable(cache_freq_133))
		else $error("frequency changed inside processor reset");

	c_write: cover property (cmd == dcsp_pkg::CMD_WRITE);
	c_read: cover property (cmd == dcsp_pkg::CMD_READ);
	c_refresh: cover property (cmd == dcsp_pkg::CMD_REFRESH);
	c_drop: cover property ($fell(cache_pins_owned));
endmodule
bind dcsp_port dcsp_port_asserts u_dcsp_port_asserts (.*);
`default_nettype wire

// ===== tb/dcsp_sdram_model.sv
// behavioural sdram array behind the display cache pins
// assumes one open row at a time, read data only at the cas latency edge
`timescale 1ns/1ps
`default_nettype none
module dcsp_sdram_model (
	input  wire logic        ref_clk,
	input  wire logic [3:0]  cmd,
	input  wire logic [11:0] addr,
	input  wire logic [3:0]  mask,
	input  wire logic [31:0] wdata,
	input  wire logic        oe,
	output logic      [31:0] rdata
);
	logic [31:0] mem [logic [19:0]];
	logic [11:0] row;
	logic [31:0] word;
	logic [31:0] pend;
	int          hold;
	initial rdata = 32'h0;
	initial hold = 0;
	always @(posedge ref_clk)
	begin
		if (cmd == dcsp_pkg::CMD_ACTIVE)
			row = addr;
		word = mem.exists({row, addr[7:0]}) ? mem[{row, addr[7:0]}] : 32'h0;
		if (cmd == dcsp_pkg::CMD_WRITE && oe)
		begin
			for (int i = 0; i < 4; i++)
				if (!mask[i])
					word[8*i +: 8] = wdata[8*i +: 8];
			mem[{row, addr[7:0]}] = word;
		end
		// released bus toggles; a word stands for one edge, two after read
		if (cmd == dcsp_pkg::CMD_READ)
		begin
			pend = (mask == 4'h0) ? word : ~word;
			hold = 2;
			rdata <= #1 ~rdata;
		end
		else if (hold == 2)
		begin
			rdata <= #1 pend;
			hold = 1;
		end
		else
		begin
			hold = 0;
			rdata <= #1 ~rdata;
		end
	end
endmodule
`default_nettype wire

// ===== tb/tb_display_cache_sdram_port.sv
// self-checking bench for the display cache sdram port
// assumes dcsp_port with a short init count and the sdram model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
	failures++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb_display_cache_sdram_port;
	logic ref_clk, rst, graphics_enabled, processor_reset_n;
	logic cache_frequency_select, cache_fsel_pullup_en, cache_freq_133;
	logic cache_pins_owned, cache_chip_select_n, cache_row_strobe_n;
	logic cache_column_strobe_n, cache_write_enable_n, cache_mem_data_oe;
	logic [11:0] cache_mem_address;
	logic [3:0]  cache_data_mask, req_byte_en;
	logic [31:0] cache_mem_data_in, cache_mem_data_out, req_wdata, rd_data;
	logic        req_valid, req_ready, req_write, rd_valid, rd_ready;
	logic [19:0] req_addr;
	int          failures = 0;
	int          total_checks = 0;
	int          refs = 0;
	wire logic [3:0] cmd = {cache_chip_select_n, cache_row_strobe_n,
		cache_column_strobe_n, cache_write_enable_n};

	dcsp_port #(.INIT_CYCLES(20), .FIFO_DEPTH(16)) u_dcsp_port (.*);
	dcsp_sdram_model u_dcsp_sdram_model (
		.ref_clk (ref_clk),
		.cmd     (cmd),
		.addr    (cache_mem_address),
		.mask    (cache_data_mask),
		.wdata   (cache_mem_data_out),
		.oe      (cache_mem_data_oe),
		.rdata   (cache_mem_data_in)
	);

	initial
	begin
		ref_clk = 0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
		if (cmd == dcsp_pkg::CMD_REFRESH)
			refs++;

	// ====================================================
	// shared tasks
	task automatic end_sim;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic must(input bit ok);
		`CHK("handshake", 1'b1, ok)
		if (!ok)
			end_sim();
	endtask
	// holds the request until it is taken or the bound runs out
	task automatic send(input logic w, input logic [19:0] a,
		input logic [31:0] d, input logic [3:0] be, input int lim,
		output bit ok);
		ok = 0;
		req_valid = 1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		req_byte_en = be;
		repeat (lim)
		begin
			@(negedge ref_clk);
			ok = req_ready;
			step(1);
			if (ok)
				break;
		end
		req_valid = 0;
		// let an edge pass with valid low so a following request raises it afresh
		step(1);
	endtask
	task automatic pop(input int lim, output logic [31:0] d, output bit ok);
		ok = 0;
		repeat (lim)
		begin
			@(negedge ref_clk);
			if (rd_valid === 1'b1)
			begin
				ok = 1;
				d = rd_data;
				break;
			end
		end
		if (ok)
		begin
			step(1);
			rd_ready = 1;
			step(1);
			rd_ready = 0;
		end
	endtask
	task automatic wr(input logic [19:0] a, input logic [31:0] d,
		input logic [3:0] be);
		bit ok;
		send(1, a, d, be, 100, ok);
		must(ok);
	endtask
	task automatic rd(input logic [19:0] a, input logic [31:0] e);
		bit          ok;
		logic [31:0] d;
		send(0, a, 32'h0, 4'h0, 100, ok);
		must(ok);
		pop(30, d, ok);
		must(ok);
		`CHK("read word", e, d)
	endtask

	// ====================================================
	// scenarios
	task automatic t_reset_vals;
		`CHK("freq after reset", 1'b1, cache_freq_133)
		`CHK("pullup after reset", 1'b1, cache_fsel_pullup_en)
		`CHK("ready in init", 1'b0, req_ready)
	endtask
	task automatic t_rw;
		wr(20'h12345, 32'h11223344, 4'hF);
		wr(20'h12345, 32'hAABBCCDD, 4'h5);
		wr(20'hABC5A, 32'h0F0F5AA5, 4'hF);
		rd(20'h12345, 32'h11BB33DD);
		rd(20'hABC5A, 32'h0F0F5AA5);
	endtask
	task automatic t_fifo;
		bit          ok;
		int          n;
		int          m;
		logic [31:0] d;
		n = 0;
		m = 0;
		for (int i = 0; i < 24; i++)
		begin
			send(0, 20'hABC5A, 32'h0, 4'h0, 40, ok);
			if (!ok)
				break;
			n++;
		end
		`CHK("words held", 17, n)
		for (int i = 0; i < 24; i++)
		begin
			pop(30, d, ok);
			if (!ok)
				break;
			m++;
			`CHK("drained word", 32'h0F0F5AA5, d)
		end
		`CHK("words drained", n, m)
	endtask
	task automatic t_strap;
		cache_frequency_select = 0;
		processor_reset_n = 0;
		step(8);
		`CHK("pullup in reset", 1'b1, cache_fsel_pullup_en)
		processor_reset_n = 1;
		step(8);
		`CHK("freq strap low", 1'b0, cache_freq_133)
		`CHK("pullup released", 1'b0, cache_fsel_pullup_en)
		cache_frequency_select = 1;
		step(8);
		`CHK("freq kept", 1'b0, cache_freq_133)
		processor_reset_n = 0;
		step(8);
		processor_reset_n = 1;
		step(8);
		`CHK("freq strap high", 1'b1, cache_freq_133)
	endtask
	task automatic t_refresh;
		refs = 0;
		step(1700);
		`CHK("refresh seen", 1'b1, refs > 0)
	endtask
	task automatic t_graphics;
		bit ok;
		graphics_enabled = 0;
		step(2);
		`CHK("pins owned", 1'b0, cache_pins_owned)
		`CHK("strobes idle", 4'hF, cmd)
		`CHK("data released", 1'b0, cache_mem_data_oe)
		send(0, 20'h12345, 32'h0, 4'h0, 10, ok);
		`CHK("refused", 1'b0, ok)
		graphics_enabled = 1;
		rd(20'h12345, 32'h11BB33DD);
	endtask

	initial
	begin
		rst = 1;
		graphics_enabled = 1;
		processor_reset_n = 1;
		cache_frequency_select = 1;
		req_valid = 0;
		req_write = 0;
		req_addr = 20'h0;
		req_wdata = 32'h0;
		req_byte_en = 4'h0;
		rd_ready = 0;
		step(2);
		rst = 0;
		t_reset_vals();
		t_rw();
		t_fifo();
		t_strap();
		t_refresh();
		t_graphics();
		end_sim();
	end
endmodule
`default_nettype wire
